// ===== exec_pkg.sv
// Shared constants, register map and types for the execution block
package exec_pkg;
    // Register byte offsets on the APB bus
    localparam logic [7:0] CTRL_OFS = 8'h00; // Go, next-is-two-word
    localparam logic [7:0] INSTR_OFS = 8'h04; // First and second word
    localparam logic [7:0] WORK_OFS = 8'h08; // working_register
    localparam logic [7:0] BANK_OFS = 8'h0C; // bank_select_register
    localparam logic [7:0] STATUS_OFS = 8'h10; // Flags, busy, skip
    localparam logic [7:0] PC_OFS = 8'h14; // Program counter
    localparam logic [7:0] MADDR_OFS = 8'h18; // Data memory pointer
    localparam logic [7:0] MDATA_OFS = 8'h1C; // Data memory window
    localparam logic [7:0] CYCLES_OFS = 8'h20; // Cycles of last instruction
    // Control and status field positions
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_TWO_BIT = 1;
    localparam int FLAG_C = 0; // Carry
    localparam int FLAG_DC = 1; // digit_carry_flag
    localparam int FLAG_Z = 2;
    localparam int FLAG_OV = 3;
    localparam int FLAG_N = 4;
    localparam int STAT_BUSY_BIT = 8;
    localparam int STAT_SKIP_BIT = 9;
    // Reset values
    localparam logic [7:0] WORK_RST = 8'h00;
    localparam logic [3:0] BANK_RST = 4'h0;
    localparam logic [4:0] FLAGS_RST = 5'h00;
    localparam logic [20:0] PC_RST = 21'h000000;
    // Timing: Q phases per instruction cycle
    localparam logic [3:0] Q_PER_CYCLE = 4'h4;
    // Shortcut bank halves when the bank access bit is zero
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
    // Adjust constants for decimal adjust
    localparam logic [8:0] BCD_LOW_ADJ = 9'h006;
    localparam logic [8:0] BCD_HIGH_ADJ = 9'h060;
    localparam logic [3:0] BCD_MAX_DIGIT = 4'h9;
    // Opcode patterns
    localparam logic [6:0] OPC_CP_LESS = 7'h30; // 0110 000
    localparam logic [6:0] OPC_CP_EQUAL = 7'h31; // 0110 001
    localparam logic [6:0] OPC_CP_GREATER = 7'h32; // 0110 010
    localparam logic [5:0] OPC_DEC_SKIP_Z = 6'h0B; // 0010 11
    localparam logic [5:0] OPC_DEC_SKIP_NZ = 6'h13; // 0100 11
    localparam logic [5:0] OPC_INC = 6'h0A; // 0010 10
    localparam logic [5:0] OPC_DEC = 6'h01; // 0000 01
    localparam logic [15:0] OPC_DAW = 16'h0007;
    localparam logic [7:0] OPC_JUMP_HI = 8'hEF; // First word upper byte
    localparam logic [3:0] OPC_JUMP_W2 = 4'hF; // Second word marker

    // Decoded operations
    typedef enum logic [3:0] {
        OP_NONE, OP_CP_LESS, OP_CP_EQUAL, OP_CP_GREATER, OP_DEC_SKIP_Z,
        OP_DEC_SKIP_NZ, OP_INC, OP_DEC, OP_DAW, OP_JUMP
    } op_t;

    // Execution sequencer states, one per Q phase
    typedef enum logic [2:0] {
        ST_IDLE, ST_DECODE, ST_READ, ST_PROCESS, ST_WRITE, ST_NOP
    } state_t;
endpackage

// ===== data_ram.sv
// Single-port data memory with registered read data
`timescale 1ns/100ps
module data_ram #(
    parameter int AW = 12,
    parameter int DW = 8
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    output logic [DW-1:0] rdata
);
    // Storage array, not reset: contents are software's business
    logic [DW-1:0] mem [0:(1<<AW)-1];
    logic [DW-1:0] rdata_d;

    // Read is old data when written in the same cycle
    always_comb begin
        rdata_d = mem[addr];
    end

    // Array write
    always_ff @(posedge mclk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end

    // Read data register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata <= '0;
        end else begin
            rdata <= rdata_d;
        end
    end
endmodule // data_ram

// ===== compare_skip_decrement_jump_exec.sv
// Execution unit for compare/skip, decrement/skip, inc, adjust and jump
// Notes on behaviour
// [RULE1] Greater compare: unsigned subtract, no writes, flags kept
// [RULE2] Skip next when register above working register
// [RULE3] Less compare skips only when register below
// [RULE4] Skip discards prefetch; two cycles total
// [RULE5] Skipping over two-word instruction: three cycles
// [RULE6] Decrement, write destination, skip on zero
// [RULE7] Decrement, write destination, skip on nonzero
// [RULE8] Destination bit one: register; zero: working
// [RULE9] Access bit zero uses shortcut bank, ignores bank
// [RULE10] Jump loads literal into PC bits 20:1
// [RULE11] Jump: two words, two cycles, second idle
// [RULE12] Decimal adjust each nibble, carry set on overflow
`timescale 1ns/100ps
module compare_skip_decrement_jump_exec #(
    parameter int AW = 12 // Data memory address width
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic exec_busy
);
    exec_pkg::state_t state_q, state_d;
    exec_pkg::op_t op;
    logic [31:0] instr_q, instr_d; // Word two in 31:16
    logic two_q, two_d; // Following instruction is two words
    logic [7:0] w_q, w_d; // working_register
    logic [3:0] bank_q, bank_d; // bank_select_register
    logic [4:0] flags_q, flags_d;
    logic [20:0] pc_q, pc_d;
    logic [AW-1:0] maddr_q, maddr_d;
    logic [7:0] res_q, res_d; // Result of the process phase
    logic [4:0] rflags_q, rflags_d; // Flags computed with the result
    logic skip_q, skip_d;
    logic [3:0] nop_q, nop_d; // Q phases of idle slots left
    logic [1:0] cycles_q, cycles_d;
    logic [31:0] prdata_d;
    logic pready_d, pslverr_d;
    // Memory port
    logic [AW-1:0] mem_addr;
    logic mem_we;
    logic [7:0] mem_wdata, rd;
    logic [8:0] t9, daw9;
    logic apb_commit, apb_setup, wr_ok;

    // Operation decode shared by sequencer and checks
    function automatic exec_pkg::op_t decode(input logic [31:0] iw);
        decode = exec_pkg::OP_NONE;
        if (iw[15:9] == exec_pkg::OPC_CP_LESS) decode = exec_pkg::OP_CP_LESS;
        if (iw[15:9] == exec_pkg::OPC_CP_EQUAL)
            decode = exec_pkg::OP_CP_EQUAL;
        if (iw[15:9] == exec_pkg::OPC_CP_GREATER)
            decode = exec_pkg::OP_CP_GREATER;
        if (iw[15:10] == exec_pkg::OPC_DEC_SKIP_Z)
            decode = exec_pkg::OP_DEC_SKIP_Z;
        if (iw[15:10] == exec_pkg::OPC_DEC_SKIP_NZ)
            decode = exec_pkg::OP_DEC_SKIP_NZ;
        if (iw[15:10] == exec_pkg::OPC_INC) decode = exec_pkg::OP_INC;
        if (iw[15:10] == exec_pkg::OPC_DEC) decode = exec_pkg::OP_DEC;
        if (iw[15:0] == exec_pkg::OPC_DAW) decode = exec_pkg::OP_DAW;
        if (iw[15:8] == exec_pkg::OPC_JUMP_HI &&
            iw[31:28] == exec_pkg::OPC_JUMP_W2) decode = exec_pkg::OP_JUMP;
    endfunction

    // Bank address of operand f
    function automatic logic [11:0] eff_addr(input logic [31:0] iw,
                                             input logic [3:0] bank_select_register);
        if (iw[8]) eff_addr = {bank_select_register, iw[7:0]};
        else eff_addr = {iw[7] ? exec_pkg::ACCESS_HIGH_BANK
                               : exec_pkg::ACCESS_LOW_BANK, iw[7:0]};
    endfunction

    data_ram #(.AW(AW), .DW(8)) u_ram (
        .mclk(mclk),
        .rst(rst),
        .we(mem_we),
        .addr(mem_addr),
        .wdata(mem_wdata),
        .rdata(rd)
    );

    assign op = decode(instr_q);
    assign apb_setup = psel && !penable;
    // Write or read completes only at the edge that sees pready
    assign apb_commit = psel && penable && pready;
    // Software writes are refused while an instruction runs
    assign wr_ok = apb_commit && pwrite && state_q == exec_pkg::ST_IDLE;

    // Memory port: sequencer owns it while busy, else the bus window
    always_comb begin
        mem_addr = maddr_q;
        mem_we = 1'b0;
        mem_wdata = pwdata[7:0];
        if (state_q != exec_pkg::ST_IDLE) begin
            mem_addr = AW'(eff_addr(instr_q, bank_q)); // RULE9
            mem_wdata = res_q;
            mem_we = state_q == exec_pkg::ST_WRITE && instr_q[9] &&
                (op == exec_pkg::OP_DEC_SKIP_Z ||
                 op == exec_pkg::OP_DEC_SKIP_NZ ||
                 op == exec_pkg::OP_INC || op == exec_pkg::OP_DEC); // RULE8
        end else if (wr_ok && paddr == exec_pkg::MDATA_OFS) begin
            mem_we = 1'b1;
        end
    end

    // Decimal adjust: low nibble first, then high nibble with carry
    always_comb begin
        t9 = {1'b0, w_q};
        if (w_q[3:0] > exec_pkg::BCD_MAX_DIGIT || flags_q[exec_pkg::FLAG_DC])
            t9 = t9 + exec_pkg::BCD_LOW_ADJ; // RULE12
        daw9 = t9;
        if (t9[7:4] > exec_pkg::BCD_MAX_DIGIT || flags_q[exec_pkg::FLAG_C] ||
            t9[8])
            daw9 = t9 + exec_pkg::BCD_HIGH_ADJ; // RULE12
    end

    // Sequencer next state and datapath
    always_comb begin
        state_d = state_q;
        instr_d = instr_q;
        two_d = two_q;
        w_d = w_q;
        bank_d = bank_q;
        flags_d = flags_q;
        pc_d = pc_q;
        maddr_d = maddr_q;
        res_d = res_q;
        rflags_d = rflags_q;
        skip_d = skip_q;
        nop_d = nop_q;
        cycles_d = cycles_q;
        case (state_q)
            exec_pkg::ST_IDLE: begin
                // Register writes from software
                if (wr_ok) begin
                    case (paddr)
                        exec_pkg::CTRL_OFS: begin
                            two_d = pwdata[exec_pkg::CTRL_TWO_BIT];
                            if (pwdata[exec_pkg::CTRL_GO_BIT]) begin
                                state_d = exec_pkg::ST_DECODE;
                                skip_d = 1'b0;
                            end
                        end
                        exec_pkg::INSTR_OFS: instr_d = pwdata;
                        exec_pkg::WORK_OFS: w_d = pwdata[7:0];
                        exec_pkg::BANK_OFS: bank_d = pwdata[3:0];
                        exec_pkg::STATUS_OFS: flags_d = pwdata[4:0];
                        exec_pkg::PC_OFS: pc_d = {pwdata[20:1], 1'b0};
                        exec_pkg::MADDR_OFS: maddr_d = pwdata[AW-1:0];
                        default: begin
                            // Read-only, unmapped or memory window (written through the memory port): no register stored
                        end
                    endcase
                end
            end
            // Q1 decode, Q2 register read issued
            exec_pkg::ST_DECODE: state_d = exec_pkg::ST_READ;
            exec_pkg::ST_READ: state_d = exec_pkg::ST_PROCESS;
            exec_pkg::ST_PROCESS: begin
                // Q3: operand is in rd
                state_d = exec_pkg::ST_WRITE;
                res_d = rd;
                rflags_d = flags_q;
                skip_d = 1'b0;
                case (op)
                    exec_pkg::OP_CP_GREATER: skip_d = rd > w_q; // RULE1 RULE2
                    exec_pkg::OP_CP_LESS: skip_d = rd < w_q; // RULE3
                    exec_pkg::OP_CP_EQUAL: skip_d = rd == w_q;
                    exec_pkg::OP_DEC_SKIP_Z: begin
                        res_d = rd - 8'h01;
                        skip_d = rd == 8'h01; // RULE6
                    end
                    exec_pkg::OP_DEC_SKIP_NZ: begin
                        res_d = rd - 8'h01;
                        skip_d = rd != 8'h01; // RULE7
                    end
                    exec_pkg::OP_INC, exec_pkg::OP_DEC: begin
                        res_d = op == exec_pkg::OP_INC ? rd + 8'h01
                                                       : rd - 8'h01;
                        rflags_d[exec_pkg::FLAG_C] = op == exec_pkg::OP_INC ?
                            rd == 8'hFF : rd != 8'h00;
                        rflags_d[exec_pkg::FLAG_DC] = op == exec_pkg::OP_INC ?
                            rd[3:0] == 4'hF : rd[3:0] != 4'h0;
                        rflags_d[exec_pkg::FLAG_OV] = op == exec_pkg::OP_INC ?
                            rd == 8'h7F : rd == 8'h80;
                        rflags_d[exec_pkg::FLAG_Z] = res_d == 8'h00;
                        rflags_d[exec_pkg::FLAG_N] = res_d[7];
                    end
                    exec_pkg::OP_DAW: begin
                        res_d = daw9[7:0];
                        rflags_d[exec_pkg::FLAG_C] =
                            flags_q[exec_pkg::FLAG_C] | daw9[8]; // RULE12
                    end
                    default: begin
                        // Jump and unknown codes compute nothing here
                    end
                endcase
            end
            exec_pkg::ST_WRITE: begin
                // Q4: destination write and program counter update
                flags_d = rflags_q;
                if ((op == exec_pkg::OP_DEC_SKIP_Z ||
                     op == exec_pkg::OP_DEC_SKIP_NZ ||
                     op == exec_pkg::OP_INC || op == exec_pkg::OP_DEC) &&
                    !instr_q[9])
                    w_d = res_q; // RULE8
                if (op == exec_pkg::OP_DAW) w_d = res_q;
                cycles_d = 2'd1;
                nop_d = 4'h0;
                pc_d = pc_q + 21'd2;
                state_d = exec_pkg::ST_IDLE;
                if (op == exec_pkg::OP_JUMP) begin
                    pc_d = {instr_q[27:16], instr_q[7:0], 1'b0}; // RULE10
                    nop_d = exec_pkg::Q_PER_CYCLE; // RULE11
                    cycles_d = 2'd2;
                    state_d = exec_pkg::ST_NOP;
                end else if (skip_q) begin
                    // Prefetched word(s) dropped, one idle cycle per word in their place
                    pc_d = two_q ? pc_q + 21'd6 : pc_q + 21'd4; // RULE4 RULE5
                    nop_d = two_q ? exec_pkg::Q_PER_CYCLE << 1
                                  : exec_pkg::Q_PER_CYCLE; // RULE4 RULE5
                    cycles_d = two_q ? 2'd3 : 2'd2; // RULE5
                    state_d = exec_pkg::ST_NOP;
                end
            end
            exec_pkg::ST_NOP: begin
                // Every Q phase of the extra cycles does nothing
                nop_d = nop_q - 4'h1;
                if (nop_q == 4'h1) state_d = exec_pkg::ST_IDLE;
            end
            default: state_d = exec_pkg::ST_IDLE;
        endcase
    end

    // Sequencer registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q <= exec_pkg::ST_IDLE;
            instr_q <= 32'h00000000;
            two_q <= 1'b0;
            w_q <= exec_pkg::WORK_RST;
            bank_q <= exec_pkg::BANK_RST;
            flags_q <= exec_pkg::FLAGS_RST;
            pc_q <= exec_pkg::PC_RST;
            maddr_q <= '0;
            res_q <= 8'h00;
            rflags_q <= exec_pkg::FLAGS_RST;
            skip_q <= 1'b0;
            nop_q <= 4'h0;
            cycles_q <= 2'd0;
        end else begin
            state_q <= state_d;
            instr_q <= instr_d;
            two_q <= two_d;
            w_q <= w_d;
            bank_q <= bank_d;
            flags_q <= flags_d;
            pc_q <= pc_d;
            maddr_q <= maddr_d;
            res_q <= res_d;
            rflags_q <= rflags_d;
            skip_q <= skip_d;
            nop_q <= nop_d;
            cycles_q <= cycles_d;
        end
    end

    // APB answer: one wait state so memory read data can be registered
    always_comb begin
        pready_d = psel && penable && !pready;
        pslverr_d = 1'b0;
        prdata_d = prdata;
        if (apb_setup) prdata_d = 32'h00000000;
        if (pready_d) begin
            case (paddr)
                exec_pkg::CTRL_OFS: prdata_d = {30'h0, two_q, 1'b0};
                exec_pkg::INSTR_OFS: prdata_d = instr_q;
                exec_pkg::WORK_OFS: prdata_d = {24'h0, w_q};
                exec_pkg::BANK_OFS: prdata_d = {28'h0, bank_q};
                exec_pkg::STATUS_OFS: prdata_d = {22'h0, skip_q,
                    state_q != exec_pkg::ST_IDLE, 3'h0, flags_q};
                exec_pkg::PC_OFS: prdata_d = {11'h0, pc_q};
                exec_pkg::MADDR_OFS: prdata_d = 32'(maddr_q);
                exec_pkg::MDATA_OFS: prdata_d = {24'h0, rd};
                exec_pkg::CYCLES_OFS: prdata_d = {30'h0, cycles_q};
                default: pslverr_d = 1'b1; // Unmapped address
            endcase
            // Busy engine refuses writes and the memory window
            if (state_q != exec_pkg::ST_IDLE &&
                (pwrite || paddr == exec_pkg::MDATA_OFS))
                pslverr_d = 1'b1;
            if (pwrite) prdata_d = 32'h00000000;
        end
    end

    // APB output registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            exec_busy <= 1'b0;
        end else begin
            prdata <= prdata_d;
            pready <= pready_d;
            pslverr <= pslverr_d;
            exec_busy <= state_d != exec_pkg::ST_IDLE;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_compare_no_write: assert property ( // RULE1
        state_q == exec_pkg::ST_WRITE && op == exec_pkg::OP_CP_GREATER
        |-> !mem_we ##1 $stable(flags_q) && $stable(w_q))
        else $error("compare changed a flag or register");
    a_greater_skip: assert property ( // RULE2
        state_q == exec_pkg::ST_PROCESS && op == exec_pkg::OP_CP_GREATER
        |=> skip_q == ($past(rd) > w_q))
        else $error("greater compare skip decision wrong");
    a_less_skip: assert property ( // RULE3
        state_q == exec_pkg::ST_PROCESS && op == exec_pkg::OP_CP_LESS
        |=> skip_q == ($past(rd) < w_q))
        else $error("less compare skip decision wrong");
    a_skip_one_slot: assert property ( // RULE4
        state_q == exec_pkg::ST_WRITE && skip_q && !two_q &&
        op != exec_pkg::OP_JUMP
        |=> (state_q == exec_pkg::ST_NOP)[*4] ##1 state_q == exec_pkg::ST_IDLE)
        else $error("single skip slot length wrong");
    a_skip_two_slots: assert property ( // RULE5
        state_q == exec_pkg::ST_WRITE && skip_q && two_q &&
        op != exec_pkg::OP_JUMP
        |=> (state_q == exec_pkg::ST_NOP)[*8] ##1 cycles_q == 2'd3)
        else $error("two-word skip length wrong");
    a_dec_zero_skip: assert property ( // RULE6
        state_q == exec_pkg::ST_PROCESS && op == exec_pkg::OP_DEC_SKIP_Z
        |=> skip_q == (res_q == 8'h00) && $stable(flags_q))
        else $error("decrement zero skip wrong");
    a_dec_nonzero_skip: assert property ( // RULE7
        state_q == exec_pkg::ST_PROCESS && op == exec_pkg::OP_DEC_SKIP_NZ
        |=> skip_q == (res_q != 8'h00))
        else $error("decrement nonzero skip wrong");
    a_dest_working: assert property ( // RULE8
        state_q == exec_pkg::ST_WRITE && op == exec_pkg::OP_DEC && !instr_q[9]
        |-> !mem_we ##1 w_q == $past(res_q))
        else $error("destination select wrong");
    a_bank_shortcut: assert property ( // RULE9
        state_q == exec_pkg::ST_READ && !instr_q[8]
        |-> mem_addr[11:8] == (instr_q[7] ? 4'hF : 4'h0))
        else $error("shortcut bank not used");
    a_jump_target: assert property ( // RULE10
        state_q == exec_pkg::ST_WRITE && op == exec_pkg::OP_JUMP
        |=> pc_q == {instr_q[27:16], instr_q[7:0], 1'b0})
        else $error("jump target wrong");
    a_jump_cycles: assert property ( // RULE11
        state_q == exec_pkg::ST_DECODE && op == exec_pkg::OP_JUMP
        |-> ##3 (1'b1) ##1 (state_q == exec_pkg::ST_NOP)[*4]
        ##1 state_q == exec_pkg::ST_IDLE)
        else $error("jump cycle count wrong");
    a_bcd_carry: assert property ( // RULE12
        state_q == exec_pkg::ST_WRITE && op == exec_pkg::OP_DAW &&
        $past(flags_q[exec_pkg::FLAG_C])
        |=> flags_q[exec_pkg::FLAG_C])
        else $error("decimal adjust lost carry");
    c_skip_two: cover property (state_q == exec_pkg::ST_WRITE && skip_q &&
        two_q);
    c_jump: cover property (state_q == exec_pkg::ST_WRITE &&
        op == exec_pkg::OP_JUMP);
    c_bcd: cover property (state_q == exec_pkg::ST_WRITE &&
        op == exec_pkg::OP_DAW && res_q != w_q);
endmodule // compare_skip_decrement_jump_exec

// ===== compare_skip_decrement_jump_exec_tb_top.sv
// Self-checking bench for the execution block over APB
`timescale 1ns/100ps
module compare_skip_decrement_jump_exec_tb_top;
    logic mclk, rst, psel, penable, pwrite, pready, pslverr, exec_busy;
    logic [7:0] paddr, f, v, wm, res, fw; // Bus address, model operands
    logic [31:0] pwdata, prdata, rd; // Bus data, last read
    logic e; // Slave error of last transfer
    logic [15:0] sd = 16'h2B05; // Random state
    logic [15:0] iw; // Instruction word
    logic [23:0] k; // Jump literal
    logic [3:0] bk, bu; // Bank register, bank actually used
    logic [4:0] fl; // Model flags
    logic a, d, two, sk; // Access, destination, two-word, skip
    logic [8:0] t; // Adjust sum with carry
    int num_errors = 0, n_tests = 0, cyc = 0, pc_m = 0, nb = 0, b0 = 0;

    compare_skip_decrement_jump_exec dut_u (.mclk(mclk), .rst(rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .exec_busy(exec_busy));

    // Free-running clock, 50 ns period
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // Hang guard, well above the expected run length
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        // Busy samples, so run length is seen on the pin itself
        if (exec_busy === 1'b1) nb <= nb + 1;
        if (cyc == 30000) begin
            num_errors++;
            finish_test();
        end
    end

    // Random byte from a shift register
    function automatic logic [7:0] rnd();
        sd = {sd[14:0], sd[15] ^ sd[13] ^ sd[12] ^ sd[10]};
        return sd[7:0];
    endfunction

    task automatic chk(input string nm, input logic [31:0] s, x);
        n_tests++;
        if (s !== x) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, x, s);
        end
    endtask

    // One APB transfer; held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] ad,
                       input logic [31:0] dt);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= dt;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input string nm, input logic [7:0] ad,
                         input logic [31:0] x);
        apb(1'b0, ad, 32'h0);
        chk(nm, rd, x);
    endtask

    // Load, start, and wait out one instruction
    task automatic run(input logic [15:0] w1, w2);
        b0 = nb;
        apb(1'b1, exec_pkg::INSTR_OFS, {w2, w1});
        apb(1'b1, exec_pkg::CTRL_OFS, {30'h0, two, 1'b1});
        // A jump keeps busy long enough to see a write refused
        if (w2 != 16'h0000) begin
            apb(1'b1, exec_pkg::WORK_OFS, 32'h000000FF);
            chk("busy write", {31'h0, e}, 32'h1);
        end
        @(posedge mclk);
        while (exec_busy !== 1'b0) @(posedge mclk);
    endtask

    // Compare visible state with the model
    task automatic chkall(input logic [1:0] nc);
        rdchk("pc", exec_pkg::PC_OFS, 32'(pc_m));
        rdchk("cycles", exec_pkg::CYCLES_OFS, {30'h0, nc});
        chk("busy", 32'(nb - b0), 32'(4 * nc));
        rdchk("status", exec_pkg::STATUS_OFS, {22'h0, sk, 4'h0, fl});
        rdchk("w", exec_pkg::WORK_OFS, {24'h0, wm});
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        // W, bank, status and PC all clear
        for (int i = 2; i < 6; i++) rdchk("reset", 8'(4 * i), 32'h0);
        rdchk("unmapped", 8'h40, 32'h0);
        chk("unmapped err", {31'h0, e}, 32'h1);
        $display("test reset done");
        for (int i = 0; i < 40; i++) begin
            f = rnd();
            v = rnd();
            wm = rnd();
            res = rnd();
            fw = rnd();
            {bk, two, d, a} = res[7:1];
            fl = fw[4:0];
            // Force equality and decrement-to-zero cases
            if (i % 4 == 0) v = wm;
            if (i % 4 == 1) v = 8'h01;
            bu = a ? bk : (f < 8'h80 ? 4'h0 : 4'hF);
            apb(1'b1, exec_pkg::BANK_OFS, {28'h0, bk});
            apb(1'b1, exec_pkg::WORK_OFS, {24'h0, wm});
            apb(1'b1, exec_pkg::MADDR_OFS, {20'h0, bu, f});
            apb(1'b1, exec_pkg::MDATA_OFS, {24'h0, v});
            apb(1'b1, exec_pkg::STATUS_OFS, {27'h0, fl});
            res = v - 8'h01;
            case (i % 7)
                0: begin
                    iw = {exec_pkg::OPC_CP_LESS, a, f};
                    sk = v < wm;
                end
                1: begin
                    iw = {exec_pkg::OPC_CP_EQUAL, a, f};
                    sk = v == wm;
                end
                2: begin
                    iw = {exec_pkg::OPC_CP_GREATER, a, f};
                    sk = v > wm;
                end
                3: begin
                    iw = {exec_pkg::OPC_DEC_SKIP_Z, d, a, f};
                    sk = res == 8'h00;
                end
                // Plain increment and decrement: flags {N,OV,Z,DC,C}
                5: begin
                    iw = {exec_pkg::OPC_INC, d, a, f};
                    res = v + 8'h01;
                    fl = {res[7], v == 8'h7F, res == 8'h00,
                        v[3:0] == 4'hF, v == 8'hFF};
                    sk = 1'b0;
                end
                6: begin
                    iw = {exec_pkg::OPC_DEC, d, a, f};
                    fl = {res[7], v == 8'h80, res == 8'h00,
                        v[3:0] != 4'h0, v != 8'h00};
                    sk = 1'b0;
                end
                default: begin
                    iw = {exec_pkg::OPC_DEC_SKIP_NZ, d, a, f};
                    sk = res != 8'h00;
                end
            endcase
            run(iw, 16'h0000);
            if (i % 7 > 2) begin
                if (d) v = res;
                else wm = res;
            end
            pc_m = (pc_m + (sk ? (two ? 6 : 4) : 2)) % 2097152;
            chkall(sk ? (two ? 2'h3 : 2'h2) : 2'h1);
            rdchk("mem", exec_pkg::MDATA_OFS, {24'h0, v});
        end
        $display("test skip group done");
        two = 1'b0;
        sk = 1'b0;
        for (int i = 0; i < 4; i++) begin
            k[7:0] = rnd();
            k[15:8] = rnd();
            k[23:16] = rnd();
            run({8'hEF, k[7:0]}, {4'hF, k[19:8]});
            pc_m = int'({k[19:0], 1'b0});
            chkall(2'h2);
        end
        $display("test jump done");
        for (int i = 0; i < 8; i++) begin
            wm = rnd();
            fw = rnd();
            fl = (i == 0) ? 5'h00 : fw[4:0];
            if (i == 0) wm = 8'hA5;
            // Keep clear of nibble cases that read two ways
            if (wm[7:4] == 4'h9 || wm[7:4] == 4'hF) wm[4] = 1'b0;
            apb(1'b1, exec_pkg::WORK_OFS, {24'h0, wm});
            apb(1'b1, exec_pkg::STATUS_OFS, {27'h0, fl});
            run(exec_pkg::OPC_DAW, 16'h0000);
            t = {1'b0, wm};
            if (wm[3:0] > 4'h9 || fl[1]) t = t + 9'h006;
            if (t[7:4] > 4'h9 || fl[0]) t = t + 9'h060;
            fl[0] = fl[0] | t[8];
            wm = t[7:0];
            pc_m = (pc_m + 2) % 2097152;
            chkall(2'h1);
        end
        $display("test adjust done");
        finish_test();
    end
endmodule // compare_skip_decrement_jump_exec_tb_top
